// ==== core/watchdog_timeout_and_halt_control.sv ====
`timescale 1ns/10ps
// Overview of operation
// RQ1: Software keeps counter top bit set on writes
// RQ2: Timeout set by low six counter bits
// RQ3: Timeout count field is bits five to zero
// RQ4: Timebase selection shapes exact tick timing
// RQ5: Slow and wait modes leave watchdog unchanged
// RQ6: Plain halt: decrement once, then freeze silently
// RQ7: Plain halt wake resumes after startup delay
// RQ8: Reset out of halt leaves watchdog disabled
// RQ9: Halt with halt-reset option resets device
// RQ10: Active halt holds counter, no reset
// RQ11: Interrupt ends active halt, resume immediately
// RQ12: Reset ends active halt, resume after delay
// RQ13: Hardware option keeps watchdog always active
// RQ14: Software refreshes counter before halting
// RQ15: Counter steps every 16384 clocks, always; code steps only in run mode and shortens one tick per timebase group
// RQ16: Rollover 40h to 3Fh pulls reset low
// RQ17: Activate bit set by software, cleared by reset
// RQ18: Activate set with top bit clear resets
// RQ19: No interrupt request, only device reset
module watchdog_timeout_and_halt_control
  import wdg_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF,
  parameter int RESET_PULSE = RESET_PULSE_CYCLES,
  parameter int STARTUP_LONG = STARTUP_LONG_CYCLES
)
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [ADDR_W-1:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  input wire logic i_hw_watchdog_option,
  input wire logic i_halt_reset_option,
  input wire logic i_halt_request,
  input wire logic i_external_interrupt,
  input wire logic i_oscillator_interrupt,
  input wire logic i_long_startup,
  output logic o_reset_pin_low,
  output logic o_halted,
  output logic o_active_halt
);
  localparam int PW = $clog2(RESET_PULSE + 1);
  // Wide enough for whichever startup delay is longer
  localparam int SW = $clog2(((STARTUP_LONG > STARTUP_SHORT_CYCLES) ?
    STARTUP_LONG : STARTUP_SHORT_CYCLES) + 1);

  // Whole block state
  typedef struct packed {
    logic awready; // Write address ready
    logic wready; // Write data ready
    logic bvalid; // Write response valid
    logic [1:0] bresp; // Write response code
    logic arready; // Read address ready
    logic rvalid; // Read data valid
    logic [31:0] rdata; // Read data word
    logic [1:0] rresp; // Read response code
    logic aw_full; // Write address held
    logic [ADDR_W-1:0] aw_addr; // Held write address
    logic w_full; // Write data held
    logic [31:0] wdata; // Held write data
    logic [3:0] wstrb; // Held byte strobes
    logic activate; // Software activation
    logic [6:0] counter; // Downcounter, top bit and count
    logic [1:0] timebase; // Timebase select
    logic rtc_ie; // Real-time-clock interrupt enable
    mode_type mode; // Power mode
    logic [SW-1:0] startup_count; // Startup delay progress
    logic reset_low; // Reset pin pulled low
    logic [PW-1:0] pulse_count; // Reset pulse progress
    logic [1:0] cause; // Last reset cause
    logic halted; // Plain halt flag
    logic active_halt; // Active halt flag
  } state_type;

  state_type s;
  state_type next_s;
  logic tick; // Prescaler step
  logic run_tick; // Step taken in run mode
  logic effective_active; // Watchdog may reset
  logic write_fire; // Held write executes
  sel_type write_sel; // Write target
  sel_type read_sel; // Read target
  logic ctrl_write; // Control register written
  logic sw_reset; // Software reset request
  logic expiry; // Rollover 40h to 3Fh
  logic halt_now; // Halt instruction in run mode
  logic halt_reset; // Halt turned into reset
  logic plain_entry; // Entering plain halt
  logic [SW-1:0] startup_last; // Final startup count
  logic [31:0] read_word; // Word for current read

  // Step source; runs only in run mode so halts freeze it
  wdg_tick_divider #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_divider (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_enable(s.mode == MODE_RUN),
    .i_timebase_select(s.timebase),
    .o_tick(tick)
  );

  // Event decode; slow and wait need no input at all
  assign effective_active = s.activate | i_hw_watchdog_option; // RQ13
  assign run_tick = tick && (s.mode == MODE_RUN); // RQ5
  assign write_fire = s.aw_full && s.w_full && !s.bvalid;
  assign write_sel = map_select(s.aw_addr);
  assign read_sel = map_select(i_araddr);
  assign ctrl_write = write_fire && (write_sel == SEL_CTRL) && s.wstrb[0];
  assign sw_reset = ctrl_write && !s.wdata[TOP_BIT] && // RQ18
    (effective_active || s.wdata[ACTIVATE_BIT]);
  // Plain halt entry never resets, even when its step clears the top bit
  assign expiry = run_tick && effective_active && !ctrl_write &&
    !plain_entry && (s.counter == EXPIRY_FROM); // RQ16
  assign halt_now = (s.mode == MODE_RUN) && i_halt_request && !s.reset_low;
  assign halt_reset = halt_now && !s.rtc_ie && i_halt_reset_option; // RQ9
  assign plain_entry = halt_now && !s.rtc_ie && !i_halt_reset_option; // RQ6
  assign startup_last = i_long_startup ? SW'(STARTUP_LONG - 1) :
    SW'(STARTUP_SHORT_CYCLES - 1);

  // Read data mux; no interrupt state exists to show
  always_comb
  begin
    read_word = '0;
    unique case (read_sel)
      SEL_CTRL: read_word[7:0] = {s.activate, s.counter};
      SEL_CONFIG: read_word[2:0] = {s.rtc_ie, s.timebase};
      SEL_STATUS: read_word[5:0] = {effective_active, s.cause,
        s.reset_low, s.mode};
      SEL_NONE: read_word = '0;
    endcase
  end

  // Next-state logic for bus, counter, modes and reset pulse
  always_comb
  begin
    next_s = s;
    // Write address and data accepted in either order
    if (i_awvalid && s.awready)
    begin
      next_s.aw_full = 1'b1;
      next_s.aw_addr = i_awaddr;
      next_s.awready = 1'b0;
    end
    if (i_wvalid && s.wready)
    begin
      next_s.w_full = 1'b1;
      next_s.wdata = i_wdata;
      next_s.wstrb = i_wstrb;
      next_s.wready = 1'b0;
    end
    // Both held: perform write and answer
    if (write_fire)
    begin
      next_s.aw_full = 1'b0;
      next_s.w_full = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = (write_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      if ((write_sel == SEL_CONFIG) && s.wstrb[0])
      begin
        next_s.timebase = s.wdata[TIMEBASE_LSB +: 2]; // RQ4
        next_s.rtc_ie = s.wdata[RTC_IE_BIT];
      end
    end
    // Response taken: reopen both write channels
    if (s.bvalid && i_bready)
    begin
      next_s.bvalid = 1'b0;
      next_s.awready = 1'b1;
      next_s.wready = 1'b1;
    end
    // Read answered one cycle after address
    if (i_arvalid && s.arready)
    begin
      next_s.arready = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rdata = read_word;
      next_s.rresp = (read_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    if (s.rvalid && i_rready)
    begin
      next_s.rvalid = 1'b0;
      next_s.arready = 1'b1;
    end
    // Activation only ever sets; reset alone clears it
    if (ctrl_write && s.wdata[ACTIVATE_BIT])
      next_s.activate = 1'b1; // RQ17
    // Counter: write wins, else halt step, else tick step
    if (ctrl_write)
      next_s.counter = s.wdata[6:0]; // RQ3 RQ2
    else if (plain_entry)
      next_s.counter = s.counter - 7'h01; // RQ6
    else if (run_tick)
      next_s.counter = s.counter - 7'h01; // RQ15
    // Reset pulse timing and cause
    if (s.reset_low)
    begin
      if (s.pulse_count == PW'(RESET_PULSE - 1))
        next_s.reset_low = 1'b0;
      else
        next_s.pulse_count = s.pulse_count + PW'(1);
    end
    else if (sw_reset || expiry || halt_reset)
    begin
      next_s.reset_low = 1'b1;
      next_s.pulse_count = '0;
      if (halt_reset)
        next_s.cause = CAUSE_HALT;
      else if (sw_reset)
        next_s.cause = CAUSE_SOFTWARE;
      else
        next_s.cause = CAUSE_EXPIRY;
    end
    // Power mode sequencing
    unique case (s.mode)
      MODE_RUN:
      begin
        if (halt_now && s.rtc_ie)
          next_s.mode = MODE_ACTIVE_HALT; // RQ10
        else if (plain_entry)
          next_s.mode = MODE_PLAIN_HALT; // RQ6
      end
      MODE_PLAIN_HALT:
      begin
        // Wake by external interrupt only, then delay
        if (i_external_interrupt)
        begin
          next_s.mode = MODE_STARTUP; // RQ7
          next_s.startup_count = '0;
        end
      end
      MODE_STARTUP:
      begin
        // Counting held until the delay has run out
        if (s.startup_count >= startup_last)
          next_s.mode = MODE_RUN; // RQ12
        else
          next_s.startup_count = s.startup_count + SW'(1);
      end
      MODE_ACTIVE_HALT:
      begin
        // Either interrupt resumes counting at once
        if (i_oscillator_interrupt || i_external_interrupt)
          next_s.mode = MODE_RUN; // RQ11
      end
    endcase
    next_s.halted = (next_s.mode == MODE_PLAIN_HALT);
    next_s.active_halt = (next_s.mode == MODE_ACTIVE_HALT);
  end

  // State register; reset enters startup with watchdog disabled unless the hardware option is set
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      s <= '0;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
      s.counter <= COUNTER_RESET;
      s.activate <= ACTIVATE_RESET; // RQ8
      s.timebase <= TIMEBASE_RESET;
      s.mode <= MODE_STARTUP; // RQ12
      s.cause <= CAUSE_NONE;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Outputs straight from state; no interrupt output exists
  assign o_awready = s.awready;
  assign o_wready = s.wready;
  assign o_bvalid = s.bvalid;
  assign o_bresp = s.bresp;
  assign o_arready = s.arready;
  assign o_rvalid = s.rvalid;
  assign o_rdata = s.rdata;
  assign o_rresp = s.rresp;
  assign o_reset_pin_low = s.reset_low; // RQ19
  assign o_halted = s.halted;
  assign o_active_halt = s.active_halt;

  // Plain-halt wake with short delay
  sequence seq_plain_wake;
    s.mode == MODE_PLAIN_HALT && i_external_interrupt && !i_long_startup;
  endsequence

  // Startup held 256 cycles, then run
  sequence seq_short_startup;
    (s.mode == MODE_STARTUP) [*8] ##248 (s.mode == MODE_STARTUP)
      ##1 (s.mode == MODE_RUN);
  endsequence

  AST_HALT_RESET: assert property ( // RQ9
    @(posedge i_clk) disable iff (i_reset)
    halt_reset |=> s.reset_low && s.cause == CAUSE_HALT)
    else $error("halt with option did not reset");

  AST_PLAIN_HALT_STEP: assert property ( // RQ6
    @(posedge i_clk) disable iff (i_reset)
    plain_entry && !ctrl_write |=> s.mode == MODE_PLAIN_HALT &&
      s.counter == $past(s.counter) - 7'h01 && !$rose(s.reset_low))
    else $error("plain halt entry wrong");

  AST_PLAIN_FROZEN: assert property ( // RQ6
    @(posedge i_clk) disable iff (i_reset)
    s.mode == MODE_PLAIN_HALT && !ctrl_write && !s.reset_low
      |=> $stable(s.counter) && !s.reset_low)
    else $error("plain halt counter moved or reset");

  AST_WAKE_DELAY: assert property ( // RQ7
    @(posedge i_clk) disable iff (i_reset)
    seq_plain_wake |=> seq_short_startup)
    else $error("startup delay not 256 cycles");

  AST_ACTIVE_HOLD: assert property ( // RQ10
    @(posedge i_clk) disable iff (i_reset)
    s.mode == MODE_ACTIVE_HALT && !ctrl_write |=> $stable(s.counter))
    else $error("active halt counter moved");

  AST_ACTIVE_WAKE: assert property ( // RQ11
    @(posedge i_clk) disable iff (i_reset)
    s.mode == MODE_ACTIVE_HALT &&
      (i_oscillator_interrupt || i_external_interrupt)
      |=> s.mode == MODE_RUN)
    else $error("active halt wake not immediate");

  AST_EXPIRY: assert property ( // RQ16
    @(posedge i_clk) disable iff (i_reset)
    expiry && !s.reset_low |=> s.reset_low && s.counter == 7'h3F)
    else $error("expiry did not pull reset");

  AST_PULSE_HELD: assert property ( // RQ16
    @(posedge i_clk) disable iff (i_reset)
    s.reset_low && s.pulse_count != PW'(RESET_PULSE - 1) |=> s.reset_low)
    else $error("reset pulse ended early");

  AST_ACTIVATE_STICKY: assert property ( // RQ17
    @(posedge i_clk) disable iff (i_reset)
    s.activate |=> s.activate)
    else $error("activation bit cleared");

  AST_SW_RESET: assert property ( // RQ18
    @(posedge i_clk) disable iff (i_reset)
    ctrl_write && s.wdata[ACTIVATE_BIT] && !s.wdata[TOP_BIT] && !s.reset_low
      |=> s.reset_low && s.cause == CAUSE_SOFTWARE)
    else $error("software reset missing");

  AST_HW_OPTION: assert property ( // RQ13
    @(posedge i_clk) disable iff (i_reset)
    run_tick && i_hw_watchdog_option && !ctrl_write && !s.reset_low &&
      !plain_entry && s.counter == EXPIRY_FROM |=> s.reset_low)
    else $error("hardware option did not force reset");
endmodule

// ==== core/wdg_tick_divider.sv ====
`timescale 1ns/10ps
module wdg_tick_divider
  import wdg_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
)
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_enable,
  input wire logic [1:0] i_timebase_select,
  output logic o_tick
);
  localparam int CW = $clog2(TICK_CYCLES + 1);

  // Divider state
  typedef struct packed {
    logic [CW-1:0] cycles; // Clocks into current tick
    logic [3:0] group; // Tick index within timebase group
    logic tick; // One-cycle step pulse
  } div_state_type;

  div_state_type s;
  div_state_type next_s;
  logic [3:0] group_last; // Last tick of the group
  logic [CW-1:0] period; // Length of current tick
  int short_len; // Shortened tick length

  // Every timebase event resyncs one tick, making it short
  always_comb
  begin
    group_last = 4'((timebase_msb(i_timebase_select) >> 2) - 6'h01);
    short_len = TICK_CYCLES - (((LSB_SPAN -
      int'(timebase_lsb(i_timebase_select))) * TICK_CYCLES)
      >> TICK_SCALE_SHIFT);
    period = (s.group == group_last) ? CW'(short_len) : CW'(TICK_CYCLES);
    next_s = s;
    next_s.tick = 1'b0;
    // Frozen while disabled, keeping its phase
    if (i_enable)
    begin
      if (s.cycles >= period - CW'(1))
      begin
        next_s.cycles = '0;
        next_s.tick = 1'b1; // RQ15
        next_s.group = (s.group >= group_last) ? 4'h0 : s.group + 4'h1; // RQ4
      end
      else
      begin
        next_s.cycles = s.cycles + CW'(1);
      end
    end
  end

  // State register
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      s <= '0;
    else
      s <= next_s;
  end

  assign o_tick = s.tick;
endmodule

// ==== include/wdg_pkg.sv ====
package wdg_pkg;
  // Clock rate of the block
  localparam int CLK_PERIOD_NS = 5;
  // Prescaler ticks: one counter step per this many clocks
  localparam int TICK_CYCLES_DEF = 16384;
  // Short tick shortfall: (SPAN - lsb) * tick >> SHIFT
  localparam int LSB_SPAN = 64;
  localparam int TICK_SCALE_SHIFT = 8;
  // Startup delays after wake-up, in clocks
  localparam int STARTUP_SHORT_CYCLES = 256;
  localparam int STARTUP_LONG_CYCLES = 4096;
  // Reset pin low time
  localparam int RESET_PULSE_NS = 30000;
  localparam int RESET_PULSE_CYCLES = RESET_PULSE_NS / CLK_PERIOD_NS;
  // Register bus
  localparam int ADDR_W = 4;
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] CONFIG_OFFSET = 4'h4;
  localparam logic [3:0] STATUS_OFFSET = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Control register fields
  localparam int ACTIVATE_BIT = 7;
  localparam int TOP_BIT = 6;
  localparam logic [6:0] COUNTER_RESET = 7'h7F;
  localparam logic ACTIVATE_RESET = 1'h0;
  localparam logic [6:0] EXPIRY_FROM = 7'h40;
  // Config register fields
  localparam int TIMEBASE_LSB = 0;
  localparam int RTC_IE_BIT = 2;
  localparam logic [1:0] TIMEBASE_RESET = 2'h0;
  // Reset causes shown in status
  localparam logic [1:0] CAUSE_NONE = 2'h0;
  localparam logic [1:0] CAUSE_EXPIRY = 2'h1;
  localparam logic [1:0] CAUSE_SOFTWARE = 2'h2;
  localparam logic [1:0] CAUSE_HALT = 2'h3;

  // Register select codes
  typedef enum logic [1:0] {
    SEL_CTRL = 2'h0,
    SEL_CONFIG = 2'h1,
    SEL_STATUS = 2'h2,
    SEL_NONE = 2'h3
  } sel_type;

  // Power mode states, Gray along run, halt, startup
  typedef enum logic [1:0] {
    MODE_RUN = 2'h0,
    MODE_PLAIN_HALT = 2'h1,
    MODE_STARTUP = 2'h3,
    MODE_ACTIVE_HALT = 2'h2
  } mode_type;

  // Address decode shared by read and write paths
  function automatic sel_type map_select(input logic [3:0] addr);
    unique case (addr)
      CTRL_OFFSET: map_select = SEL_CTRL;
      CONFIG_OFFSET: map_select = SEL_CONFIG;
      STATUS_OFFSET: map_select = SEL_STATUS;
      default: map_select = SEL_NONE;
    endcase
  endfunction

  // Timebase 2ms, 4ms, 10ms, 25ms: MSB column
  function automatic logic [5:0] timebase_msb(input logic [1:0] tb);
    unique case (tb)
      2'h0: timebase_msb = 6'h04;
      2'h1: timebase_msb = 6'h08;
      2'h2: timebase_msb = 6'h14;
      2'h3: timebase_msb = 6'h31;
    endcase
  endfunction

  // Timebase 2ms, 4ms, 10ms, 25ms: LSB column
  function automatic logic [5:0] timebase_lsb(input logic [1:0] tb);
    unique case (tb)
      2'h0: timebase_lsb = 6'h3B;
      2'h1: timebase_lsb = 6'h35;
      2'h2: timebase_lsb = 6'h23;
      2'h3: timebase_lsb = 6'h36;
    endcase
  endfunction
endpackage

// ==== testbench/watchdog_timeout_and_halt_control_bench.sv ====
`timescale 1ns/10ps
module watchdog_timeout_and_halt_control_bench
  import wdg_pkg::*;
;
  // Shortened counts for a quick run
  localparam int TICK = 256;
  localparam int PULSE = 16;
  localparam int SLONG = 64;
  // Table row: one register access and its outcome
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic [1:0] resp;
    logic [31:0] rdata;
  } row_type;
  // Clock, reset and bus drive
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic awvalid = 1'h0;
  logic [3:0] awaddr = 4'h0;
  logic wvalid = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic [3:0] araddr = 4'h0;
  logic rready = 1'h0;
  // Options and wake-up events
  logic hw_opt = 1'h0;
  logic halt_opt = 1'h0;
  logic halt_req = 1'h0;
  logic ext_irq = 1'h0;
  logic osc_irq = 1'h0;
  logic long_start = 1'h0;
  // Design outputs
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic pin_low, halted, act_halt;
  // Bookkeeping
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int t0, t1, lat;
  logic [1:0] resp;
  logic [31:0] val, keep;
  // Ordinary register cases: config codes and an unmapped place
  row_type rows [5] = '{
    '{CONFIG_OFFSET, 32'h4, RESP_OKAY, 32'h4},
    '{CONFIG_OFFSET, 32'h1, RESP_OKAY, 32'h1},
    '{CONFIG_OFFSET, 32'hFFFF_FFFA, RESP_OKAY, 32'h2},
    '{CONFIG_OFFSET, 32'h7, RESP_OKAY, 32'h7},
    '{4'hC, 32'h55, RESP_SLVERR, 32'h0}};

  watchdog_timeout_and_halt_control #(
    .TICK_CYCLES(TICK),
    .RESET_PULSE(PULSE),
    .STARTUP_LONG(SLONG)
  ) u_dut (
    .i_clk(clk), .i_reset(reset),
    .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
    .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata),
    .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready),
    .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready),
    .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready),
    .o_rdata(rdata), .o_rresp(rresp),
    .i_hw_watchdog_option(hw_opt), .i_halt_reset_option(halt_opt),
    .i_halt_request(halt_req), .i_external_interrupt(ext_irq),
    .i_oscillator_interrupt(osc_irq), .i_long_startup(long_start),
    .o_reset_pin_low(pin_low), .o_halted(halted),
    .o_active_halt(act_halt));

  // 200 MHz clock and a free cycle count
  always #2.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  // Verdict and end of run
  task automatic wrap_up();
    if (bad_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Compare a register word
  task automatic check_reg(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Compare a single flag
  task automatic check_flag(input string what, input logic exp,
    input logic got);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Status word as the design lays it out
  function automatic logic [31:0] st(input logic a, input logic [1:0] c,
    input logic [1:0] m);
    st = {26'h0, a, c, 1'h0, m};
  endfunction

  // Synchronous reset held for four edges
  task automatic do_reset();
    @(posedge clk);
    reset <= 1'h1;
    repeat (4) @(posedge clk);
    reset <= 1'h0;
  endtask

  // Bus write: address and data together, held until taken
  task automatic bus_write(input logic [3:0] a, input logic [31:0] d,
    output logic [1:0] r);
    bit got;
    got = 1'b0;
    r = 2'h1;
    @(posedge clk);
    awvalid <= 1'h1;
    awaddr <= a;
    wvalid <= 1'h1;
    wdata <= d;
    bready <= 1'h1;
    while (!got)
    begin
      @(posedge clk);
      if (awvalid && awready)
        awvalid <= 1'h0;
      if (wvalid && wready)
        wvalid <= 1'h0;
      if (bvalid === 1'h1)
      begin
        r = bresp;
        got = 1'b1;
        bready <= 1'h0;
      end
    end
  endtask

  // Bus read: address held until taken, data taken with rvalid
  task automatic bus_read(input logic [3:0] a, output logic [31:0] d,
    output logic [1:0] r);
    bit got;
    got = 1'b0;
    r = 2'h1;
    d = 32'hDEAD_BEEF;
    @(posedge clk);
    arvalid <= 1'h1;
    araddr <= a;
    rready <= 1'h1;
    while (!got)
    begin
      @(posedge clk);
      if (arvalid && arready)
        arvalid <= 1'h0;
      if (rvalid === 1'h1)
      begin
        d = rdata;
        r = rresp;
        got = 1'b1;
        rready <= 1'h0;
      end
    end
  endtask

  // Short forms
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus_write(a, d, resp);
  endtask
  task automatic rd(input logic [3:0] a);
    bus_read(a, val, resp);
  endtask

  // Poll the counter until it steps, note the cycle
  task automatic wait_step(output int t);
    rd(CTRL_OFFSET);
    keep = val;
    while (val[6:0] === keep[6:0])
      rd(CTRL_OFFSET);
    keep = val;
    t = cyc;
  endtask

  // Wait for the reset pin, then measure its low time
  task automatic see_pulse(input int lim, output int l);
    int w;
    l = 0;
    w = 0;
    while (pin_low !== 1'h1 && l < lim)
    begin
      @(posedge clk);
      l++;
    end
    while (pin_low === 1'h1 && w < 100)
    begin
      @(posedge clk);
      w++;
    end
    check_flag("reset pin seen", 1'h1, l < lim);
    check_reg("reset pulse length", 32'(PULSE), 32'(w));
  endtask

  // Hang guard
  initial
  begin
    #500000;
    bad_count++;
    wrap_up();
  end

  // Main sequence
  initial
  begin
    do_reset();
    rd(CTRL_OFFSET);
    check_reg("control after reset", 32'h7F, val);
    rd(STATUS_OFFSET);
    check_reg("reset status", st(0, CAUSE_NONE, MODE_STARTUP), val);
    foreach (rows[i])
    begin
      bus_write(rows[i].addr, rows[i].wdata, resp);
      check_reg("write resp", 32'(rows[i].resp), 32'(resp));
      bus_read(rows[i].addr, val, resp);
      check_reg("read resp", 32'(rows[i].resp), 32'(resp));
      check_reg("read data", rows[i].rdata, val);
    end
    rd(STATUS_OFFSET);
    check_reg("startup mode", 32'(MODE_STARTUP), 32'(val[1:0]));
    repeat (230) @(posedge clk);
    rd(STATUS_OFFSET);
    check_reg("run mode", 32'(MODE_RUN), 32'(val[1:0]));
    // Free-running count while disabled, 2 ms timebase
    wr(CONFIG_OFFSET, 32'h0);
    wait_step(t0);
    wait_step(t1);
    lat = t1 - t0;
    check_flag("tick spacing", 1'h1, lat >= 246 && lat <= 256);
    // Plain halt right at the edge of expiry
    wait_step(t0);
    wr(CTRL_OFFSET, 32'hC0);
    @(posedge clk) halt_req <= 1'h1;
    @(posedge clk) halt_req <= 1'h0;
    repeat (2) @(posedge clk);
    check_flag("plain halt", 1'h1, halted);
    rd(CTRL_OFFSET);
    check_reg("one step in halt", 32'hBF, val);
    repeat (600) @(posedge clk);
    rd(CTRL_OFFSET);
    check_reg("frozen in halt", 32'hBF, val);
    rd(STATUS_OFFSET);
    check_reg("quiet halt", st(1, CAUSE_NONE, MODE_PLAIN_HALT), val);
    @(posedge clk) ext_irq <= 1'h1;
    @(posedge clk) ext_irq <= 1'h0;
    repeat (240) @(posedge clk);
    rd(STATUS_OFFSET);
    check_reg("wake delay", 32'(MODE_STARTUP), 32'(val[1:0]));
    repeat (20) @(posedge clk);
    rd(STATUS_OFFSET);
    check_reg("wake done", 32'(MODE_RUN), 32'(val[1:0]));
    wr(CTRL_OFFSET, 32'h7F);
    rd(CTRL_OFFSET);
    check_flag("activate sticky", 1'h1, val[7]);
    // Active halt with the halt-reset option set
    wr(CONFIG_OFFSET, 32'h4);
    halt_opt <= 1'h1;
    wait_step(t0);
    @(posedge clk) halt_req <= 1'h1;
    @(posedge clk) halt_req <= 1'h0;
    repeat (2) @(posedge clk);
    check_flag("active halt", 1'h1, act_halt);
    repeat (600) @(posedge clk);
    rd(CTRL_OFFSET);
    check_reg("held in active halt", keep, val);
    rd(STATUS_OFFSET);
    check_reg("halt status", st(1, CAUSE_NONE, MODE_ACTIVE_HALT), val);
    @(posedge clk) osc_irq <= 1'h1;
    @(posedge clk) osc_irq <= 1'h0;
    @(posedge clk);
    check_flag("left active halt", 1'h0, act_halt);
    rd(STATUS_OFFSET);
    check_reg("resumed at once", st(1, CAUSE_NONE, MODE_RUN), val);
    // Halt with the option set and no rtc interrupt
    wr(CONFIG_OFFSET, 32'h0);
    @(posedge clk) halt_req <= 1'h1;
    @(posedge clk) halt_req <= 1'h0;
    see_pulse(4, lat);
    check_flag("no halt entered", 1'h0, halted);
    rd(STATUS_OFFSET);
    check_reg("halt cause", 32'(CAUSE_HALT), 32'(val[4:3]));
    halt_opt <= 1'h0;
    do_reset();
    rd(CTRL_OFFSET);
    check_reg("disabled after reset", 32'h7F, val);
    // Expiry after a count of one
    repeat (270) @(posedge clk);
    wait_step(t0);
    wr(CTRL_OFFSET, 32'hC1);
    see_pulse(512, lat);
    check_flag("expiry time", 1'h1, lat >= 480);
    rd(CTRL_OFFSET);
    check_reg("rolled to 3F", 32'hBF, val);
    rd(STATUS_OFFSET);
    check_reg("expiry cause", 32'(CAUSE_EXPIRY), 32'(val[4:3]));
    do_reset();
    // Software reset through the top bit
    wr(CTRL_OFFSET, 32'h85);
    see_pulse(4, lat);
    rd(STATUS_OFFSET);
    check_reg("software cause", 32'(CAUSE_SOFTWARE), 32'(val[4:3]));
    // Hardware option: always active, activate bit unused
    hw_opt <= 1'h1;
    do_reset();
    rd(STATUS_OFFSET);
    check_flag("always active", 1'h1, val[5]);
    wr(CTRL_OFFSET, 32'h05);
    see_pulse(4, lat);
    // Expiry with activate clear still resets under the option
    wr(CTRL_OFFSET, 32'h40);
    see_pulse(600, lat);
    // Long startup choice
    hw_opt <= 1'h0;
    long_start <= 1'h1;
    do_reset();
    repeat (40) @(posedge clk);
    rd(STATUS_OFFSET);
    check_reg("long startup", 32'(MODE_STARTUP), 32'(val[1:0]));
    repeat (30) @(posedge clk);
    rd(STATUS_OFFSET);
    check_reg("long startup done", 32'(MODE_RUN), 32'(val[1:0]));
    wrap_up();
  end
endmodule
